// ---- core/pag_pkg.sv ----
// Constants shared by the port A GPIO block
package pag_pkg;

  localparam int unsigned PAG_PIN_COUNT = 8;
  localparam int unsigned PAG_SIO_PINS  = 4;
  localparam int unsigned PAG_SIO_BASE  = 0;
  localparam int unsigned PAG_TWI_PINS  = 3;
  localparam int unsigned PAG_TWI_BASE  = 4;

  // Register indices; byte address is index times four
  localparam int unsigned PAG_IDX_W = 15;
  localparam logic [PAG_IDX_W-1:0] PAG_IDX_OUTPUT_LATCH      = 15'h7fc8;
  localparam logic [PAG_IDX_W-1:0] PAG_IDX_PIN_LEVEL_READ    = 15'h7fc9;
  localparam logic [PAG_IDX_W-1:0] PAG_IDX_PIN_DIRECTION     = 15'h7fca;
  localparam logic [PAG_IDX_W-1:0] PAG_IDX_FUNCTION_SELECT_A = 15'h7fcb;
  localparam logic [PAG_IDX_W-1:0] PAG_IDX_FUNCTION_SELECT_B = 15'h7ffa;

  // APB address field layout
  localparam int unsigned PAG_ADDR_W    = 32;
  localparam int unsigned PAG_IDX_LSB   = 2;
  localparam int unsigned PAG_IDX_MSB   = PAG_IDX_LSB + PAG_IDX_W - 1;
  localparam int unsigned PAG_DATA_W    = 32;
  localparam int unsigned PAG_STRB_W    = 4;
  localparam int unsigned PAG_REG_W     = 8;

  localparam logic [PAG_REG_W-1:0]  PAG_REG_RESET  = 8'h00;
  localparam logic [PAG_DATA_W-1:0] PAG_DATA_ZERO  = 32'h0000_0000;
  localparam logic [1:0]            PAG_ALIGN_ZERO = 2'h0;
  localparam logic [PAG_ADDR_W-PAG_IDX_MSB-2:0] PAG_HIGH_ZERO = '0;

  // Pin mode code: {select_a, select_b, latch, direction}
  typedef enum logic [3:0] {
    PAG_M_OPEN       = 4'h0,
    PAG_M_PULLUP     = 4'h2,
    PAG_M_DRV_LOW0   = 4'h1,
    PAG_M_DRV_HIGH0  = 4'h3,
    PAG_M_SLOW_LOW   = 4'h4,
    PAG_M_SLOW_HIGH  = 4'h6,
    PAG_M_DRV_LOW1   = 4'h5,
    PAG_M_OPEN_INV   = 4'h7,
    PAG_M_LOW        = 4'h8,
    PAG_M_ALT_INV    = 4'ha,
    PAG_M_ALT_CMOS   = 4'h9,
    PAG_M_HIGH       = 4'hb,
    PAG_M_ALT_SLOWLO = 4'hc,
    PAG_M_ALT_SLOW   = 4'he,
    PAG_M_ALT_OD     = 4'hd,
    PAG_M_ALT_OPEN   = 4'hf
  } pag_mode_e;

endpackage

// ---- core/pag_sync.sv ----
// Two-flop synchroniser for the port pin levels
`timescale 1ns/1ns
module pag_sync
  import pag_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Data
  input  wire logic [PAG_PIN_COUNT-1:0] async_in,
  output logic      [PAG_PIN_COUNT-1:0] sync_out
);

  logic [PAG_PIN_COUNT-1:0] meta_ff;
  logic [PAG_PIN_COUNT-1:0] sync_ff;
  logic [PAG_PIN_COUNT-1:0] nxt_meta;
  logic [PAG_PIN_COUNT-1:0] nxt_sync;

  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;

endmodule

// ---- core/pag_pin_mode.sv ----
// Per-pin drive decoder from select, latch and direction bits
`timescale 1ns/1ns
module pag_pin_mode
  import pag_pkg::*;
(
  // Configuration
  input  wire logic fsa,
  input  wire logic fsb,
  input  wire logic lat,
  input  wire logic dir,
  // Peripheral data to send
  input  wire logic alt_data,
  // Pin drive
  output logic      drv_o,
  output logic      drv_oe,
  output logic      pull_up,
  output logic      slow,
  // Input inversions
  output logic      inv_read,
  output logic      inv_mux
);

  pag_mode_e mode;

  always_comb begin
    mode     = pag_mode_e'({fsa, fsb, lat, dir});
    drv_o    = 1'b0;
    drv_oe   = 1'b0;
    pull_up  = 1'b0;
    slow     = 1'b0;
    inv_read = 1'b0;
    inv_mux  = 1'b0;
    case (mode)
      PAG_M_OPEN: begin
      end
      PAG_M_PULLUP: begin
        pull_up = 1'b1; // [RULE9] [RULE10]
      end
      PAG_M_DRV_LOW0, PAG_M_DRV_HIGH0: begin
        drv_oe = 1'b1; // [RULE10]
        drv_o  = lat;
      end
      PAG_M_SLOW_LOW, PAG_M_SLOW_HIGH: begin
        drv_oe = 1'b1; // [RULE11]
        drv_o  = lat;
        slow   = 1'b1;
      end
      PAG_M_DRV_LOW1: begin
        drv_oe = 1'b1; // [RULE11]
      end
      PAG_M_OPEN_INV: begin
        inv_read = 1'b1; // [RULE11] [RULE4]
      end
      PAG_M_LOW: begin
        drv_oe = 1'b1; // [RULE12]
      end
      PAG_M_ALT_INV: begin
        drv_oe   = 1'b1; // [RULE12] [RULE4]
        drv_o    = ~alt_data;
        inv_read = 1'b1;
        inv_mux  = 1'b1;
      end
      PAG_M_ALT_CMOS: begin
        drv_oe = 1'b1; // [RULE12]
        drv_o  = alt_data;
      end
      PAG_M_HIGH: begin
        drv_oe = 1'b1; // [RULE12]
        drv_o  = 1'b1;
      end
      PAG_M_ALT_SLOWLO: begin
        drv_oe = 1'b1; // [RULE13]
        slow   = 1'b1;
      end
      PAG_M_ALT_SLOW: begin
        drv_oe = 1'b1; // [RULE13]
        drv_o  = alt_data;
        slow   = 1'b1;
      end
      PAG_M_ALT_OD: begin
        drv_oe = ~alt_data; // [RULE13]
      end
      PAG_M_ALT_OPEN: begin
      end
      default: begin
      end
    endcase
  end

endmodule

// ---- core/pag_port_a.sv ----
// Port A GPIO top: APB registers, pin drive and peripheral muxing
`timescale 1ns/1ns
//
// Behaviour
// RULE1 - Eight-pin port, each pin's direction set by its own direction bit.
// RULE2 - Output latch at index 7fc8, reset zero, sets output level and pull-up.
// RULE3 - Read-only pin level at index 7fc9 returns every pin regardless of direction.
// RULE4 - Pins configured for inverted input read back the complemented level.
// RULE5 - Direction register at index 7fca, read/write, reset to zero.
// RULE6 - Select registers A at 7fcb and B at 7ffa, reset zero, pick output mode.
// RULE7 - Pins 0-3 carry serial unit signals, pins 4-6 the two-wire slave signals.
// RULE8 - Pin level always reaches the multiplexed peripheral input whatever the mode; the code passes its complement in PAG_M_ALT_INV.
// RULE9 - Every pin has a software-switched pull-up.
// RULE10 - Selects 00: float, pull-up, or drive latch per latch and direction.
// RULE11 - Selects 01: slow-change latch, drive low, or float with inverted read.
// RULE12 - Selects 10: low, inverted serial data, CMOS serial data, or high.
// RULE13 - Selects 11: slow low, slow serial data, open-drain serial data, or float.
// RULE14 - After reset every pin floats with pull-up off and no output driven.
module pag_port_a
  import pag_pkg::*;
(
  // Clock and reset
  input  wire logic                     SYS_CLK,
  input  wire logic                     RST_N,
  // APB slave
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire logic [PAG_ADDR_W-1:0]    PADDR,
  input  wire logic [PAG_DATA_W-1:0]    PWDATA,
  input  wire logic [PAG_STRB_W-1:0]    PSTRB,
  output logic      [PAG_DATA_W-1:0]    PRDATA,
  output logic                          PREADY,
  output logic                          PSLVERR,
  // Port pins, split five ways
  input  wire logic [PAG_PIN_COUNT-1:0] PIN_I,
  output logic      [PAG_PIN_COUNT-1:0] PIN_O,
  output logic      [PAG_PIN_COUNT-1:0] PIN_OE,
  output logic      [PAG_PIN_COUNT-1:0] PIN_PULLUP_EN,
  output logic      [PAG_PIN_COUNT-1:0] PIN_SLOW_EN,
  // Serial unit
  input  wire logic [PAG_SIO_PINS-1:0]  SIO_OUT,
  output logic      [PAG_SIO_PINS-1:0]  SIO_IN,
  // Two-wire slave unit
  input  wire logic [PAG_TWI_PINS-1:0]  TWI_OUT,
  output logic      [PAG_TWI_PINS-1:0]  TWI_IN
);

  // Configuration registers
  logic [PAG_REG_W-1:0] output_latch_ff;
  logic [PAG_REG_W-1:0] pin_direction_ff;
  logic [PAG_REG_W-1:0] function_select_a_ff;
  logic [PAG_REG_W-1:0] function_select_b_ff;
  logic [PAG_REG_W-1:0] nxt_output_latch;
  logic [PAG_REG_W-1:0] nxt_pin_direction;
  logic [PAG_REG_W-1:0] nxt_function_select_a;
  logic [PAG_REG_W-1:0] nxt_function_select_b;

  // APB answer registers
  logic [PAG_DATA_W-1:0] prdata_ff;
  logic                  pslverr_ff;
  logic [PAG_DATA_W-1:0] nxt_prdata;
  logic                  nxt_pslverr;

  // Pin output registers
  logic [PAG_PIN_COUNT-1:0] pin_o_ff;
  logic [PAG_PIN_COUNT-1:0] pin_oe_ff;
  logic [PAG_PIN_COUNT-1:0] pin_pu_ff;
  logic [PAG_PIN_COUNT-1:0] pin_slow_ff;
  logic [PAG_PIN_COUNT-1:0] nxt_pin_o;
  logic [PAG_PIN_COUNT-1:0] nxt_pin_oe;
  logic [PAG_PIN_COUNT-1:0] nxt_pin_pu;
  logic [PAG_PIN_COUNT-1:0] nxt_pin_slow;

  // Peripheral input registers
  logic [PAG_PIN_COUNT-1:0] mux_in_ff;
  logic [PAG_PIN_COUNT-1:0] nxt_mux_in;

  // Decode and pin-side wires
  logic [PAG_PIN_COUNT-1:0] pin_level;
  logic [PAG_PIN_COUNT-1:0] alt_data;
  logic [PAG_PIN_COUNT-1:0] dec_o;
  logic [PAG_PIN_COUNT-1:0] dec_oe;
  logic [PAG_PIN_COUNT-1:0] dec_pu;
  logic [PAG_PIN_COUNT-1:0] dec_slow;
  logic [PAG_PIN_COUNT-1:0] dec_inv_read;
  logic [PAG_PIN_COUNT-1:0] dec_inv_mux;
  logic [PAG_PIN_COUNT-1:0] pin_read_value;

  logic                     apb_setup;
  logic                     apb_write_done;
  logic                     addr_in_range;
  logic [PAG_IDX_W-1:0]     reg_index;
  logic                     lane0_en;

  // Register decode
  logic                     hit_latch;
  logic                     hit_level;
  logic                     hit_dir;
  logic                     hit_fsa;
  logic                     hit_fsb;
  logic                     hit_any;
  logic [PAG_REG_W-1:0]     rd_sel;

  // Pin levels come from the board; synchronise before any use
  pag_sync u_pin_sync (
    .clk      (SYS_CLK),
    .rst_n    (RST_N),
    .async_in (PIN_I),
    .sync_out (pin_level)
  );

  // Peripheral data wanted on each pin; pin 7 has no partner
  always_comb begin
    alt_data = '0;
    alt_data[PAG_SIO_BASE +: PAG_SIO_PINS] = SIO_OUT; // [RULE7]
    alt_data[PAG_TWI_BASE +: PAG_TWI_PINS] = TWI_OUT; // [RULE7]
  end

  genvar g;
  generate
    for (g = 0; g < PAG_PIN_COUNT; g++) begin : g_pin
      pag_pin_mode u_mode (
        .fsa      (function_select_a_ff[g]),
        .fsb      (function_select_b_ff[g]),
        .lat      (output_latch_ff[g]),
        .dir      (pin_direction_ff[g]), // [RULE1]
        .alt_data (alt_data[g]),
        .drv_o    (dec_o[g]),
        .drv_oe   (dec_oe[g]),
        .pull_up  (dec_pu[g]),
        .slow     (dec_slow[g]),
        .inv_read (dec_inv_read[g]),
        .inv_mux  (dec_inv_mux[g])
      );
    end
  endgenerate

  // Read path sees the pin in every direction and mode
  assign pin_read_value = pin_level ^ dec_inv_read; // [RULE3] [RULE4]

  // APB decode
  assign apb_setup      = PSEL & ~PENABLE;
  assign apb_write_done = PSEL & PENABLE & PREADY & PWRITE & ~pslverr_ff;
  assign reg_index      = PADDR[PAG_IDX_MSB:PAG_IDX_LSB];
  assign lane0_en       = PSTRB[0];
  assign addr_in_range  = (PADDR[PAG_ADDR_W-1:PAG_IDX_MSB+1] == PAG_HIGH_ZERO) &&
                          (PADDR[PAG_IDX_LSB-1:0] == PAG_ALIGN_ZERO);

  // Decode once so the read and error paths agree on a hit;
  // a misaligned or high address hits nothing
  always_comb begin
    hit_latch = 1'b0;
    hit_level = 1'b0;
    hit_dir   = 1'b0;
    hit_fsa   = 1'b0;
    hit_fsb   = 1'b0;
    if (addr_in_range) begin
      case (reg_index)
        PAG_IDX_OUTPUT_LATCH: begin
          hit_latch = 1'b1;
        end
        PAG_IDX_PIN_LEVEL_READ: begin
          hit_level = 1'b1;
        end
        PAG_IDX_PIN_DIRECTION: begin
          hit_dir = 1'b1;
        end
        PAG_IDX_FUNCTION_SELECT_A: begin
          hit_fsa = 1'b1;
        end
        PAG_IDX_FUNCTION_SELECT_B: begin
          hit_fsb = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  assign hit_any = hit_latch | hit_level | hit_dir | hit_fsa | hit_fsb;

  // AND-OR read mux: at most one hit, so no priority chain
  assign rd_sel = ({PAG_REG_W{hit_latch}} & output_latch_ff) |
                  ({PAG_REG_W{hit_level}} & pin_read_value) | // [RULE3]
                  ({PAG_REG_W{hit_dir}}   & pin_direction_ff) |
                  ({PAG_REG_W{hit_fsa}}   & function_select_a_ff) |
                  ({PAG_REG_W{hit_fsb}}   & function_select_b_ff);

  // Configuration register group
  always_comb begin
    nxt_output_latch      = output_latch_ff;
    nxt_pin_direction     = pin_direction_ff;
    nxt_function_select_a = function_select_a_ff;
    nxt_function_select_b = function_select_b_ff;
    if (apb_write_done && lane0_en) begin
      case (reg_index)
        PAG_IDX_OUTPUT_LATCH: begin
          nxt_output_latch = PWDATA[PAG_REG_W-1:0]; // [RULE2]
        end
        PAG_IDX_PIN_DIRECTION: begin
          nxt_pin_direction = PWDATA[PAG_REG_W-1:0]; // [RULE5]
        end
        PAG_IDX_FUNCTION_SELECT_A: begin
          nxt_function_select_a = PWDATA[PAG_REG_W-1:0]; // [RULE6]
        end
        PAG_IDX_FUNCTION_SELECT_B: begin
          nxt_function_select_b = PWDATA[PAG_REG_W-1:0]; // [RULE6]
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      output_latch_ff      <= PAG_REG_RESET; // [RULE2] [RULE14]
      pin_direction_ff     <= PAG_REG_RESET; // [RULE5] [RULE14]
      function_select_a_ff <= PAG_REG_RESET; // [RULE6] [RULE14]
      function_select_b_ff <= PAG_REG_RESET; // [RULE6] [RULE14]
    end else begin
      output_latch_ff      <= nxt_output_latch;
      pin_direction_ff     <= nxt_pin_direction;
      function_select_a_ff <= nxt_function_select_a;
      function_select_b_ff <= nxt_function_select_b;
    end
  end

  // APB answer group: data and error are prepared in the setup cycle,
  // so the access phase completes at once with registered read data
  always_comb begin
    nxt_prdata  = prdata_ff;
    nxt_pslverr = pslverr_ff;
    if (apb_setup) begin
      nxt_prdata  = PAG_DATA_ZERO;
      // Refuse unmapped indices and any write to the read-only level
      nxt_pslverr = ~hit_any | (hit_level & PWRITE); // [RULE3]
      // Writes read back zero so a stale value never looks valid
      if (!PWRITE) begin
        nxt_prdata[PAG_REG_W-1:0] = rd_sel;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_ff  <= PAG_DATA_ZERO;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Zero wait states; error only meaningful while PREADY is high
  assign PREADY  = PSEL & PENABLE;
  assign PRDATA  = prdata_ff;
  assign PSLVERR = PSEL & PENABLE & pslverr_ff;

  // Pin output group, registered to keep glitches off the pads,
  // so a config write reaches the pads one edge after it lands
  always_comb begin
    nxt_pin_o    = dec_o;
    nxt_pin_oe   = dec_oe;   // [RULE1]
    nxt_pin_pu   = dec_pu;   // [RULE9]
    nxt_pin_slow = dec_slow;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_o_ff    <= '0; // [RULE14]
      pin_oe_ff   <= '0; // [RULE14]
      pin_pu_ff   <= '0; // [RULE14]
      pin_slow_ff <= '0;
    end else begin
      pin_o_ff    <= nxt_pin_o;
      pin_oe_ff   <= nxt_pin_oe;
      pin_pu_ff   <= nxt_pin_pu;
      pin_slow_ff <= nxt_pin_slow;
    end
  end

  assign PIN_O         = pin_o_ff;
  assign PIN_OE        = pin_oe_ff;
  assign PIN_PULLUP_EN = pin_pu_ff;
  assign PIN_SLOW_EN   = pin_slow_ff;

  // Peripheral input group: the level goes through in every mode but PAG_M_ALT_INV, which passes its complement
  always_comb begin
    nxt_mux_in = pin_level ^ dec_inv_mux; // [RULE8]
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mux_in_ff <= '0;
    end else begin
      mux_in_ff <= nxt_mux_in;
    end
  end

  assign SIO_IN = mux_in_ff[PAG_SIO_BASE +: PAG_SIO_PINS]; // [RULE7] [RULE8]
  assign TWI_IN = mux_in_ff[PAG_TWI_BASE +: PAG_TWI_PINS]; // [RULE7] [RULE8]

endmodule

// ---- dv/pag_port_a_chk.sv ----
// Assertions on the port A block ports
`timescale 1ns/1ns
module pag_port_a_chk
  import pag_pkg::*;
(
  // Clock and reset
  input wire logic                     SYS_CLK,
  input wire logic                     RST_N,
  // APB
  input wire logic                     PSEL,
  input wire logic                     PENABLE,
  input wire logic                     PWRITE,
  input wire logic [PAG_ADDR_W-1:0]    PADDR,
  input wire logic [PAG_DATA_W-1:0]    PRDATA,
  input wire logic                     PREADY,
  input wire logic                     PSLVERR,
  // Pins and peripheral data
  input wire logic [PAG_PIN_COUNT-1:0] PIN_O,
  input wire logic [PAG_PIN_COUNT-1:0] PIN_OE,
  input wire logic [PAG_PIN_COUNT-1:0] PIN_PULLUP_EN,
  input wire logic [PAG_PIN_COUNT-1:0] PIN_SLOW_EN,
  input wire logic [PAG_SIO_PINS-1:0]  SIO_OUT,
  input wire logic [PAG_TWI_PINS-1:0]  TWI_OUT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  a_ready_nowait: assert property (PREADY == (PSEL && PENABLE))
    else $error("PREADY not tied to the access phase");
  a_reset_quiet: assert property ($rose(RST_N) |-> PIN_OE == 8'h00 && PIN_PULLUP_EN == 8'h00)
    else $error("Pins not released after reset");
  a_rdata_upper: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h000000)
    else $error("Read data upper bits not zero");
  a_ro_write_err: assert property (PSEL && !PENABLE && PWRITE && PADDR == 32'h0001_ff24 ##1 PENABLE |-> PSLVERR)
    else $error("Write to pin level register not refused");
  a_misalign_err: assert property (PSEL && !PENABLE && PADDR[1:0] != 2'h0 ##1 PENABLE |-> PSLVERR)
    else $error("Misaligned access not refused");
  a_latch_ok: assert property (PSEL && !PENABLE && PADDR == 32'h0001_ff20 ##1 PENABLE |-> !PSLVERR)
    else $error("Latch access refused");
  a_pins_cause: assert property (!$stable({PIN_O, PIN_OE, PIN_PULLUP_EN, PIN_SLOW_EN}) |->
    $past(PREADY && PWRITE, 2) || $past(SIO_OUT) != $past(SIO_OUT, 2) || $past(TWI_OUT) != $past(TWI_OUT, 2))
    else $error("Pin drive changed without cause");
  a_pullup_float: assert property ((PIN_PULLUP_EN & (PIN_OE | PIN_SLOW_EN)) == 8'h00)
    else $error("Pull-up on a driven pin");
  a_slow_drives: assert property ((PIN_SLOW_EN & ~PIN_OE) == 8'h00)
    else $error("Slow change on an undriven pin");
  a_err_in_access: assert property (PSLVERR |-> PREADY)
    else $error("Error outside the access phase");

  c_refused: cover property (PSLVERR);
  c_pullup: cover property (PIN_PULLUP_EN != 8'h00);
  c_slow: cover property (PIN_SLOW_EN != 8'h00);
endmodule

bind pag_port_a pag_port_a_chk i_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_O(PIN_O),
  .PIN_OE(PIN_OE), .PIN_PULLUP_EN(PIN_PULLUP_EN), .PIN_SLOW_EN(PIN_SLOW_EN), .SIO_OUT(SIO_OUT),
  .TWI_OUT(TWI_OUT));

// ---- dv/pag_board.sv ----
// Board model resolving each port pin level
`timescale 1ns/1ns
module pag_board
  import pag_pkg::*;
(
  // Drive from the port
  input  wire logic [PAG_PIN_COUNT-1:0] drv,
  input  wire logic [PAG_PIN_COUNT-1:0] drv_en,
  input  wire logic [PAG_PIN_COUNT-1:0] pull_en,
  // Weak outside level on undriven pins
  input  wire logic [PAG_PIN_COUNT-1:0] ext,
  // Resolved wire
  output logic      [PAG_PIN_COUNT-1:0] level
);
  // Outside circuitry is weak, so a pulled-up pin reads high
  always_comb begin
    for (int i = 0; i < PAG_PIN_COUNT; i++) begin
      level[i] = drv_en[i] ? drv[i] : (pull_en[i] ? 1'b1 : ext[i]);
    end
  end
endmodule

// ---- dv/tb_pag_port_a.sv ----
// Self-checking bench for the port A GPIO block
`timescale 1ns/1ns
module tb_pag_port_a
  import pag_pkg::*;
();
  localparam logic [31:0] A_LAT = {15'h0000, PAG_IDX_OUTPUT_LATCH, 2'h0};
  localparam logic [31:0] A_IN  = {15'h0000, PAG_IDX_PIN_LEVEL_READ, 2'h0};
  localparam logic [31:0] A_DIR = {15'h0000, PAG_IDX_PIN_DIRECTION, 2'h0};
  localparam logic [31:0] A_FSA = {15'h0000, PAG_IDX_FUNCTION_SELECT_A, 2'h0};
  localparam logic [31:0] A_FSB = {15'h0000, PAG_IDX_FUNCTION_SELECT_B, 2'h0};
  localparam logic [31:0] RW_A [4] = '{A_LAT, A_DIR, A_FSA, A_FSB};
  localparam logic [31:0] BAD_A [3] = '{A_IN, A_LAT + 32'h1, {15'h0000, 15'h7fcc, 2'h0}};

  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] paddr   = 32'h0;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  pstrb   = 4'hf;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic [7:0]  pin_i, pin_o, pin_oe, pin_pu, pin_slow;
  logic [7:0]  ext     = 8'h00;
  logic [7:0]  ev, eo, eoe, epu, esl, einv, emx, elv;
  logic [3:0]  sio_out = 4'h0;
  logic [3:0]  sio_in;
  logic [2:0]  twi_out = 3'h0;
  logic [2:0]  twi_in;
  int          errors = 0;
  int          tests_run = 0;
  int          cycles = 0;

  pag_port_a i_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe), .PIN_PULLUP_EN(pin_pu), .PIN_SLOW_EN(pin_slow),
    .SIO_OUT(sio_out), .SIO_IN(sio_in), .TWI_OUT(twi_out), .TWI_IN(twi_in));
  pag_board i_board (.drv(pin_o), .drv_en(pin_oe), .pull_en(pin_pu), .ext(ext), .level(pin_i));

  always #20 sys_clk = ~sys_clk;

  task automatic conclude();
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Whole run needs under two hundred cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      conclude();
    end
  end

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rst_pulse();
    rst_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask

  // Bits {out, drive, pull-up, slow, read inverted, mux inverted}
  function automatic logic [5:0] mode(input logic [3:0] c, input logic alt);
    case (c)
      4'h2: mode = 6'h08;
      4'h1, 4'h5, 4'h8: mode = 6'h10;
      4'h3, 4'hb: mode = 6'h30;
      4'h4, 4'hc: mode = 6'h14;
      4'h6: mode = 6'h34;
      4'h7: mode = 6'h02;
      4'h9: mode = {alt, 5'h10};
      4'ha: mode = {~alt, 5'h13};
      4'he: mode = {alt, 5'h14};
      4'hd: mode = {1'b0, ~alt, 4'h0};
      default: mode = 6'h00;
    endcase
  endfunction

  initial begin
    rst_pulse();
    cmp("drive after reset", 32'h0, {8'h00, pin_oe, pin_pu, pin_slow});
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, RW_A[i], 32'h0);
      cmp("reset value", 32'h0, rd);
      apb(1'b1, RW_A[i], {24'hffffff, 8'h5a ^ 8'(i)});
      cmp("write accepted", 32'h0, {31'h0, err});
      apb(1'b0, RW_A[i], 32'h0);
      cmp("read back", {24'h0, 8'h5a ^ 8'(i)}, rd);
      apb(1'b1, RW_A[i], 32'h0);
    end
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, BAD_A[i], 32'hff);
      cmp("error response", 32'h1, {31'h0, err});
    end
    pstrb <= 4'he;
    apb(1'b1, A_LAT, 32'hff);
    pstrb <= 4'hf;
    apb(1'b0, A_LAT, 32'h0);
    cmp("latch after refused writes", 32'h0, rd);
    // Pin n gets mode code p*8+n, so two passes cover all sixteen modes
    for (int p = 0; p < 2; p++) begin
      for (int a = 0; a < 2; a++) begin
        ev = 8'h96 ^ {8{a[0]}};
        ext <= ev;
        sio_out <= {4{a[0]}};
        twi_out <= {3{a[0]}};
        for (int n = 0; n < 8; n++) begin
          {eo[n], eoe[n], epu[n], esl[n], einv[n], emx[n]} = mode(4'(p * 8 + n), n < 7 ? a[0] : 1'b0);
          elv[n] = eoe[n] ? eo[n] : (epu[n] | ev[n]);
        end
        apb(1'b1, A_FSA, {24'h0, {8{p[0]}}});
        apb(1'b1, A_FSB, 32'hf0);
        apb(1'b1, A_LAT, 32'hcc);
        apb(1'b1, A_DIR, 32'haa);
        repeat (6) @(posedge sys_clk);
        cmp("pin drive", {eo, eoe, epu, esl}, {pin_o, pin_oe, pin_pu, pin_slow});
        cmp("peripheral inputs", {25'h0, elv[6:0] ^ emx[6:0]}, {25'h0, twi_in, sio_in});
        apb(1'b0, A_IN, 32'h0);
        cmp("pin level read", {24'h0, elv ^ einv}, rd);
      end
    end
    rst_pulse();
    cmp("drive after second reset", 32'h0, {8'h00, pin_oe, pin_pu, pin_slow});
    apb(1'b0, A_FSA, 32'h0);
    cmp("select after second reset", 32'h0, rd);
    conclude();
  end
endmodule
